// >>> hw/mtx_cfg.svh
// constants of the motion task I/O expansion block
`ifndef MTX_CFG_SVH
`define MTX_CFG_SVH

// ----------------------------------------------------------------------
// pin counts and synchroniser layout
// ----------------------------------------------------------------------
`define MTX_N_IN       14
`define MTX_N_OUT      8
`define MTX_N_SYNC     17
`define MTX_SYN_BHOME  14
`define MTX_SYN_BNEXT  15
`define MTX_SYN_FAULT  16
`define MTX_SPEED_W    16

// ----------------------------------------------------------------------
// input function selector slots, four bits each
// ----------------------------------------------------------------------
`define MTX_FI_LAUNCH  0
`define MTX_FI_HOME    1
`define MTX_FI_CLEAR   2
`define MTX_FI_NEXT    3
`define MTX_FI_JOG     4
`define MTX_FI_RESTART 5

// ----------------------------------------------------------------------
// output function indices, three-bit selector each
// ----------------------------------------------------------------------
`define MTX_FO_TARGET  0
`define MTX_FO_LAG_OK  1
`define MTX_FO_SEQ     2
`define MTX_FO_FAULT   3
`define MTX_FO_JOG     4
`define MTX_FO_LAGW    5
`define MTX_FO_RESPW   6
`define MTX_FO_HOME    7

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define MTX_CLK_NS       8
`define MTX_ADDR_MIN_MS  4
`define MTX_START_MAX_MS 2
`define MTX_RESP_MAX_MS  10
`define MTX_NS_PER_MS    1000000

`endif

// >>> hw/mtx_pkg.sv
// types of the motion task I/O expansion block
package mtx_pkg;

  // ----------------------------------------------------------------------
  // follow-on task handler
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MTX_NX_IDLE = 2'h0,
    MTX_NX_WAIT = 2'h1,
    MTX_NX_FIRE = 2'h3
  } mtx_next_t;

  // ----------------------------------------------------------------------
  // whole block state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [16:0] s1;
    logic [16:0] s2;
    logic [16:0] s3;
    logic [7:0]  block;
    logic        mstart;
    logic        hstart;
    mtx_next_t   nstate;
    logic        nstart;
    logic        restart;
    logic        jog;
    logic [15:0] speed;
    logic        lag_warn;
    logic        resp_warn;
    logic        home;
    logic        target;
    logic        lag_ok;
    logic        seq;
    logic        fault;
    logic [7:0]  pin_out;
  } mtx_state_t;

endpackage : mtx_pkg

// >>> hw/mtx_io_exp.sv
// motion task I/O expansion front end
`timescale 1ns/100ps
`include "mtx_cfg.svh"
// How it works
// - fourteen extra input pins and eight extra output pins are provided.
// - eight select pins form an unsigned block number, pin 0 is the lsb.
// - select held 4 ms before launch; start within 2 ms, outputs in 10 ms.
// - when base home input is enabled the card home pin is ignored.
// - the clear input clears lag and response watch warnings.
// - follow-on input starts next task only after target is reached.
// - a base-unit input may also start the next motion block.
// - jog rising edge starts jog motion, falling edge cancels it.
// - jog runs at the stored jog speed value.
// - output stage overload or short sets the fault indication.
// - every output function and all six input function slots are chosen by configuration; the select pins are fixed at card pins 0 to 7.
// - launch starts selected task, or homing when block number is zero.
// - target reached output high while position is in the window.
// - lag output low while position is outside the lag window.
// - step output inverts per sequence task, low at the first task.
module mtx_io_exp #(
  parameter int START_MAX_CYC =
    `MTX_START_MAX_MS * (`MTX_NS_PER_MS / `MTX_CLK_NS)
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // card pins and base-unit pins
  input  wire logic [13:0] pin_in_i,
  input  wire logic        base_home_pin_i,
  input  wire logic        base_next_pin_i,
  input  wire logic        out_fault_pin_i,
  // configuration
  input  wire logic        base_home_en_i,
  input  wire logic [23:0] in_func_sel_i,
  input  wire logic [23:0] out_func_sel_i,
  input  wire logic [15:0] jog_speed_i,
  // amplifier status
  input  wire logic        in_window_i,
  input  wire logic        lag_outside_i,
  input  wire logic        lag_warn_set_i,
  input  wire logic        resp_warn_set_i,
  input  wire logic        task_start_i,
  input  wire logic        seq_first_i,
  // commands to the amplifier
  output logic             motion_start_o,
  output logic             homing_start_o,
  output logic [7:0]       motion_block_o,
  output logic             next_task_start_o,
  output logic             task_restart_o,
  output logic             jog_run_o,
  output logic [15:0]      jog_speed_o,
  output logic             home_sw_o,
  // status
  output logic             lag_warning_o,
  output logic             response_watch_warning_o,
  output logic             target_reached_out_o,
  output logic             lag_ok_o,
  output logic             sequence_step_toggle_o,
  output logic             out_fault_o,
  output logic [7:0]       pin_out_o
);

  mtx_pkg::mtx_state_t q;
  mtx_pkg::mtx_state_t next_q;
  logic [16:0]         rise;
  logic [16:0]         fall;
  logic [7:0]          func;
  logic                launch_r;
  logic                next_r;
  logic                jog_r;
  logic                jog_f;
  logic                clear_l;

  // ----------------------------------------------------------------------
  // function selectors
  // ----------------------------------------------------------------------
  function automatic logic pick_in(input logic [16:0] v,
                                   input logic [23:0] sel,
                                   input int          slot);
    logic [3:0] idx;
    idx = sel[slot*4 +: 4];
    pick_in = (idx < 4'hE) ? v[idx] : 1'b0;
  endfunction : pick_in

  function automatic logic pick_out(input logic [7:0]  v,
                                    input logic [23:0] sel,
                                    input int          k);
    pick_out = v[sel[k*3 +: 3]];
  endfunction : pick_out

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_q = q;
    rise = q.s2 & ~q.s3;
    fall = ~q.s2 & q.s3;
    launch_r = pick_in(rise, in_func_sel_i, `MTX_FI_LAUNCH);
    next_r = pick_in(rise, in_func_sel_i, `MTX_FI_NEXT) |
             rise[`MTX_SYN_BNEXT];
    jog_r = pick_in(rise, in_func_sel_i, `MTX_FI_JOG);
    jog_f = pick_in(fall, in_func_sel_i, `MTX_FI_JOG);
    clear_l = pick_in(q.s2, in_func_sel_i, `MTX_FI_CLEAR);
    func = '0;
    func[`MTX_FO_TARGET] = q.target;
    func[`MTX_FO_LAG_OK] = q.lag_ok;
    func[`MTX_FO_SEQ] = q.seq;
    func[`MTX_FO_FAULT] = q.fault;
    func[`MTX_FO_JOG] = q.jog;
    func[`MTX_FO_LAGW] = q.lag_warn;
    func[`MTX_FO_RESPW] = q.resp_warn;
    func[`MTX_FO_HOME] = q.home;
    // two-stage synchroniser, then edge history
    next_q.s1 = {out_fault_pin_i, base_next_pin_i, base_home_pin_i,
                 pin_in_i};
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.mstart = 1'b0;
    next_q.hstart = 1'b0;
    next_q.nstart = 1'b0;
    next_q.restart = pick_in(rise, in_func_sel_i, `MTX_FI_RESTART);
    // launch: block number zero means homing
    if (launch_r) begin
      next_q.block = q.s2[7:0];
      if (q.s2[7:0] == 8'h00) begin
        next_q.hstart = 1'b1;
      end else begin
        next_q.mstart = 1'b1;
      end
    end
    // follow-on task waits for the target
    case (q.nstate)
      mtx_pkg::MTX_NX_IDLE: begin
        if (next_r) begin
          next_q.nstate = mtx_pkg::MTX_NX_WAIT;
        end
      end
      mtx_pkg::MTX_NX_WAIT: begin
        if (in_window_i) begin
          next_q.nstart = 1'b1;
          next_q.nstate = mtx_pkg::MTX_NX_FIRE;
        end
      end
      default: begin
        next_q.nstate = mtx_pkg::MTX_NX_IDLE;
      end
    endcase
    // jog on edges
    if (jog_r) begin
      next_q.jog = 1'b1;
      next_q.speed = jog_speed_i;
    end else if (jog_f) begin
      next_q.jog = 1'b0;
    end
    // warnings: a new event wins over the clear
    if (lag_warn_set_i) begin
      next_q.lag_warn = 1'b1;
    end else if (clear_l) begin
      next_q.lag_warn = 1'b0;
    end
    if (resp_warn_set_i) begin
      next_q.resp_warn = 1'b1;
    end else if (clear_l) begin
      next_q.resp_warn = 1'b0;
    end
    if (base_home_en_i) begin
      next_q.home = q.s2[`MTX_SYN_BHOME];
    end else begin
      next_q.home = pick_in(q.s2, in_func_sel_i, `MTX_FI_HOME);
    end
    if (task_start_i) begin
      next_q.seq = seq_first_i ? 1'b0 : ~q.seq;
    end
    next_q.target = in_window_i;
    next_q.lag_ok = ~lag_outside_i;
    next_q.fault = q.s2[`MTX_SYN_FAULT];
    for (int k = 0; k < `MTX_N_OUT; k++) begin
      next_q.pin_out[k] = pick_out(func, out_func_sel_i, k);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign motion_start_o           = q.mstart;
  assign homing_start_o           = q.hstart;
  assign motion_block_o           = q.block;
  assign next_task_start_o        = q.nstart;
  assign task_restart_o           = q.restart;
  assign jog_run_o                = q.jog;
  assign jog_speed_o              = q.speed;
  assign home_sw_o                = q.home;
  assign lag_warning_o            = q.lag_warn;
  assign response_watch_warning_o = q.resp_warn;
  assign target_reached_out_o     = q.target;
  assign lag_ok_o                 = q.lag_ok;
  assign sequence_step_toggle_o   = q.seq;
  assign out_fault_o              = q.fault;
  assign pin_out_o                = q.pin_out;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  int unsigned since_launch;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || motion_start_o || homing_start_o) begin
      since_launch <= 0;
    end else if (launch_r || since_launch != 0) begin
      since_launch <= since_launch + 1;
    end
  end

  sequence launch_zero;
    launch_r && q.s2[7:0] == 8'h00;
  endsequence

  sequence launch_block;
    launch_r && q.s2[7:0] != 8'h00;
  endsequence

  a_start_bound: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i) since_launch < START_MAX_CYC)
    else $error("task start later than allowed");

  a_launch_home: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    launch_zero |=> homing_start_o && !motion_start_o)
    else $error("zero block did not start homing");

  a_block_latch: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    launch_block |=> motion_start_o && motion_block_o == $past(q.s2[7:0]))
    else $error("block number not latched at launch");

  a_block_hold: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (motion_start_o || homing_start_o) ##1 (!launch_r)[*3]
      |=> motion_block_o == $past(motion_block_o, 4))
    else $error("block number changed while task runs");

  a_next_wait: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    next_task_start_o |-> $past(in_window_i))
    else $error("follow-on task started before target");

  a_jog_start: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    jog_r |=> jog_run_o && jog_speed_o == $past(jog_speed_i))
    else $error("jog did not start with stored speed");

  a_jog_stop: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i) jog_f && !jog_r |=> !jog_run_o)
    else $error("jog not cancelled on falling edge");

  a_clear_warn: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    clear_l && !lag_warn_set_i && !resp_warn_set_i
      |=> !lag_warning_o && !response_watch_warning_o)
    else $error("warnings not cleared");

  a_seq_toggle: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    task_start_i |=> sequence_step_toggle_o ==
      ($past(seq_first_i) ? 1'b0 : !$past(sequence_step_toggle_o)))
    else $error("sequence step output wrong");

  a_home_src: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    base_home_en_i ##1 base_home_en_i[*2]
      |-> home_sw_o == $past(base_home_pin_i, 3))
    else $error("home source not the base input");

  a_fault_path: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    ##3 out_fault_o == $past(out_fault_pin_i, 3))
    else $error("fault indication latency wrong");

endmodule : mtx_io_exp

// >>> test/mtx_ctl_model.sv
// controller model that drives the card input pins
`timescale 1ns/100ps
module mtx_ctl_model #(
  parameter int ADDR_HOLD_CYC = 8
) (
  // clock
  input  wire logic        core_clk_i,
  // card input pins
  output logic      [13:0] pin_o
);
  initial pin_o = 14'h0000;

  // change the masked pins just after a falling edge
  task automatic drive(input logic [13:0] m, input logic [13:0] v);
    @(negedge core_clk_i);
    pin_o = (pin_o & ~m) | (v & m);
  endtask : drive

  // select first and hold it, then raise launch
  task automatic launch(input logic [7:0] blk);
    drive(14'h10FF, {6'h00, blk});
    repeat (ADDR_HOLD_CYC) @(negedge core_clk_i);
    pin_o[12] = 1'b1;
  endtask : launch
endmodule : mtx_ctl_model

// >>> test/tb.sv
// self-checking bench of the motion task I/O expansion block
`timescale 1ns/100ps
module tb;
  logic        core_clk_i;
  logic        reset_n_i;
  logic [13:0] pin_in_i;
  logic        base_home_pin_i, base_next_pin_i, out_fault_pin_i;
  logic        base_home_en_i, in_window_i, lag_outside_i;
  logic        lag_warn_set_i, resp_warn_set_i;
  logic        task_start_i, seq_first_i;
  logic [23:0] in_func_sel_i, out_func_sel_i;
  logic [15:0] jog_speed_i, jog_speed_o;
  logic        motion_start_o, homing_start_o, next_task_start_o;
  logic        task_restart_o, jog_run_o, home_sw_o, lag_warning_o;
  logic        response_watch_warning_o, target_reached_out_o;
  logic        lag_ok_o, sequence_step_toggle_o, out_fault_o;
  logic [7:0]  motion_block_o, pin_out_o;
  logic [7:0]  blks [5] = '{8'hAE, 8'h01, 8'h80, 8'h00, 8'hFF};
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          k, n;

  mtx_ctl_model ctl (.core_clk_i, .pin_o(pin_in_i));

  mtx_io_exp #(.START_MAX_CYC(16)) dut (
    .core_clk_i, .reset_n_i, .pin_in_i, .base_home_pin_i,
    .base_next_pin_i, .out_fault_pin_i, .base_home_en_i, .in_func_sel_i,
    .out_func_sel_i, .jog_speed_i, .in_window_i, .lag_outside_i,
    .lag_warn_set_i, .resp_warn_set_i, .task_start_i, .seq_first_i,
    .motion_start_o, .homing_start_o, .motion_block_o, .next_task_start_o,
    .task_restart_o, .jog_run_o, .jog_speed_o, .home_sw_o, .lag_warning_o,
    .response_watch_warning_o, .target_reached_out_o, .lag_ok_o,
    .sequence_step_toggle_o, .out_fault_o, .pin_out_o
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic step(input int c);
    repeat (c) @(negedge core_clk_i);
  endtask : step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_launch(input logic [7:0] blk);
    ctl.launch(blk);
    step(2);
    chk({motion_start_o, homing_start_o}, 0);
    step(1);
    chk({motion_start_o, homing_start_o}, {blk != 0, blk == 0});
    chk(motion_block_o, blk);
    ctl.drive(14'h00FF, {6'h00, ~blk});
    step(3);
    chk({motion_start_o, motion_block_o}, {1'b0, blk});
  endtask : t_launch

  task automatic t_next();
    ctl.drive(14'h0400, 14'h0400);
    step(8);
    chk(next_task_start_o, 0);
    in_window_i = 1'b1;
    step(1);
    chk(next_task_start_o, 1);
    step(1);
    chk(next_task_start_o, 0);
    ctl.drive(14'h0400, 14'h0000);
    base_next_pin_i = 1'b1;
    n = 0;
    repeat (10) begin
      step(1);
      n += next_task_start_o;
    end
    chk(n[15:0], 1);
    base_next_pin_i = 1'b0;
    in_window_i = 1'b0;
  endtask : t_next

  task automatic t_jog();
    ctl.drive(14'h0800, 14'h0800);
    step(3);
    chk({jog_run_o, jog_speed_o}, {1'b1, 16'h1234});
    jog_speed_i = 16'hBEEF;
    step(2);
    chk(jog_speed_o, 16'h1234);
    ctl.drive(14'h0800, 14'h0000);
    step(3);
    chk(jog_run_o, 0);
  endtask : t_jog

  task automatic t_warn();
    lag_warn_set_i = 1'b1;
    resp_warn_set_i = 1'b1;
    step(1);
    lag_warn_set_i = 1'b0;
    resp_warn_set_i = 1'b0;
    step(1);
    chk({lag_warning_o, response_watch_warning_o}, 2'h3);
    ctl.drive(14'h0200, 14'h0200);
    step(4);
    chk({lag_warning_o, response_watch_warning_o}, 2'h0);
    ctl.drive(14'h0200, 14'h0000);
  endtask : t_warn

  task automatic t_home();
    ctl.drive(14'h0100, 14'h0100);
    step(4);
    chk(home_sw_o, 1);
    base_home_en_i = 1'b1;
    step(4);
    chk(home_sw_o, 0);
    base_home_pin_i = 1'b1;
    step(4);
    chk(home_sw_o, 1);
    base_home_pin_i = 1'b0;
    base_home_en_i = 1'b0;
    ctl.drive(14'h0100, 14'h0000);
  endtask : t_home

  task automatic t_status();
    in_window_i = 1'b1;
    lag_outside_i = 1'b1;
    out_fault_pin_i = 1'b1;
    step(1);
    chk({target_reached_out_o, lag_ok_o}, 2'h2);
    step(4);
    chk(out_fault_o, 1);
    chk(pin_out_o, 8'h09);
    task_start_i = 1'b1;
    step(1);
    chk(sequence_step_toggle_o, 1);
    seq_first_i = 1'b1;
    step(1);
    chk(sequence_step_toggle_o, 0);
    seq_first_i = 1'b0;
    task_start_i = 1'b0;
    out_func_sel_i = 24'h000000;
    step(3);
    chk(pin_out_o, 8'hFF);
  endtask : t_status

  task automatic t_func();
    ctl.drive(14'h2000, 14'h2000);
    step(2);
    chk(task_restart_o, 0);
    step(1);
    chk(task_restart_o, 1);
    step(1);
    chk(task_restart_o, 0);
    // launch slot switched off: neither card nor base pins may launch
    in_func_sel_i = 24'hDBA98F;
    ctl.drive(14'h3000, 14'h0000);
    step(3);
    ctl.drive(14'h1000, 14'h1000);
    base_next_pin_i = 1'b1;
    n = 0;
    repeat (6) begin
      step(1);
      n += motion_start_o | homing_start_o;
    end
    chk(n[15:0], 0);
    base_next_pin_i = 1'b0;
    in_func_sel_i = 24'hDBA98C;
  endtask : t_func

  // ----------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    {reset_n_i, base_home_pin_i, base_next_pin_i, out_fault_pin_i} = 4'h0;
    {base_home_en_i, in_window_i, lag_outside_i, lag_warn_set_i} = 4'h0;
    {resp_warn_set_i, task_start_i, seq_first_i} = 3'h0;
    in_func_sel_i = 24'hDBA98C;
    out_func_sel_i = 24'hFAC688;
    jog_speed_i = 16'h1234;
    step(20);
    chk({motion_block_o, pin_out_o, jog_speed_o}, 0);
    reset_n_i = 1'b1;
    step(1);
    chk({motion_start_o, homing_start_o, next_task_start_o, jog_run_o,
         lag_warning_o, response_watch_warning_o, target_reached_out_o,
         lag_ok_o, sequence_step_toggle_o, out_fault_o, home_sw_o},
        11'h008);
    for (k = 0; k < 5; k++) begin
      t_launch(blks[k]);
    end
    t_next();
    t_jog();
    t_warn();
    t_home();
    t_status();
    t_func();
    test_done();
  end
endmodule : tb
